// ### led_pwm_channel_output_control.sv
// PWM channels with staged register updates and output drive control
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Invert bit flips outputs while enabled
// - Default: new values apply at STOP
// - STOP update covers all channel bytes together
// - Ack mode: channel updates after fourth byte
// - Drive type: 0 open-drain, 1 totem
// - Disabled field 00 low, 1x high-z
// - Disabled 01: high if totem, else high-z
// - Each channel owns on and off points
// - Two 12-bit counts per channel
// - One 12-bit counter runs and wraps
// - Output asserts at on count
// - Output negates at off count
// - Phase steps of one count
// - Off below on ends next period
// - Off-high bit 4 forces channel off
module led_pwm_channel_output_control #(
   parameter int NUM_CH = 16
) (
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic              reg_wr_in,
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic [7:0]        reg_wdata_in,
   input  wire logic              bus_stop_in,
   input  wire logic [7:0]        reg_rd_addr_in,
   output logic      [7:0]        reg_rdata_out,
   input  wire logic              pwm_tick_in,
   input  wire logic              output_enable_n_in,
   output logic      [NUM_CH-1:0] channel_output_out,
   output logic      [NUM_CH-1:0] channel_output_oe_out
);
   localparam int NB = NUM_CH * led_pwm_pkg::BYTES_PER_CH;

   logic [4:0]        cfg_q;
   logic [11:0]       cnt_q;
   logic [7:0]        stage_q [NB];
   logic [7:0]        act_q   [NB];
   logic [7:0]        nxt     [NB];
   logic [3:0]        loaded_q [NUM_CH];
   logic [NUM_CH-1:0] ch_upd;
   logic [NUM_CH-1:0] pwm_q;
   logic [NUM_CH-1:0] full_off;
   logic [11:0]       on_cnt  [NUM_CH];
   logic [11:0]       off_cnt [NUM_CH];
   logic              oe_n_meta_q;
   logic              oe_n_q;
   logic              ch_wr;
   logic [7:0]        idx;
   logic              inv;
   logic              update_timing_select;
   logic              drv;
   logic [1:0]        outne;

   assign inv   = cfg_q[led_pwm_pkg::INV_BIT];
   assign update_timing_select   = cfg_q[led_pwm_pkg::OCH_BIT];
   assign drv   = cfg_q[led_pwm_pkg::DRV_BIT];
   assign outne = cfg_q[led_pwm_pkg::OUTNE_LSB +: 2];
   assign ch_wr = reg_wr_in && reg_addr_in >= led_pwm_pkg::CH_FIRST_ADDR
                  && reg_addr_in <= led_pwm_pkg::CH_LAST_ADDR;
   assign idx   = reg_addr_in - led_pwm_pkg::CH_FIRST_ADDR;

   // Output enable pin is asynchronous to the core clock
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         oe_n_meta_q <= 1'b1;
         oe_n_q      <= 1'b1;
      end else begin
         oe_n_meta_q <= output_enable_n_in;
         oe_n_q      <= oe_n_meta_q;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cfg_q <= led_pwm_pkg::CFG_RESET;
      end else if (reg_wr_in && reg_addr_in == led_pwm_pkg::CFG_ADDR) begin
         cfg_q <= reg_wdata_in[4:0];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cnt_q <= 12'h000;
      end else if (pwm_tick_in) begin
         cnt_q <= cnt_q + led_pwm_pkg::CNT_STEP;
      end
   end

   // Staged byte plus same-cycle write forms the value to publish
   for (genvar b = 0; b < NB; b++) begin : g_byte
      localparam logic [7:0] RST_V = (b % 4 == 3) ?
         led_pwm_pkg::OFF_H_RESET : led_pwm_pkg::ON_RESET;
      logic hit;
      assign hit    = ch_wr && idx == 8'(b);
      assign nxt[b] = hit ? reg_wdata_in : stage_q[b];
      always_ff @(posedge ref_clk_in) begin
         if (rst_in) begin
            stage_q[b] <= RST_V;
         end else if (hit) begin
            stage_q[b] <= reg_wdata_in;
         end
      end
      always_ff @(posedge ref_clk_in) begin
         if (rst_in) begin
            act_q[b] <= RST_V;
         end else if ((!update_timing_select && bus_stop_in) || ch_upd[b/4]) begin
            act_q[b] <= nxt[b];
         end
      end
   end

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic wr_here;
      assign wr_here = ch_wr && idx[7:2] == 6'(c);
      assign ch_upd[c] = update_timing_select && wr_here
         && (&(loaded_q[c] | (4'h1 << idx[1:0])));
      assign on_cnt[c]  = {act_q[4*c+1][3:0], act_q[4*c]};
      assign off_cnt[c] = {act_q[4*c+3][3:0], act_q[4*c+2]};
      assign full_off[c] = act_q[4*c+3][led_pwm_pkg::FULL_OFF_BIT];

      // Mask restarts whenever the channel publishes or mode is STOP
      always_ff @(posedge ref_clk_in) begin
         if (rst_in || !update_timing_select || ch_upd[c]) begin
            loaded_q[c] <= 4'h0;
         end else if (wr_here) begin
            loaded_q[c] <= loaded_q[c] | (4'h1 << idx[1:0]);
         end
      end

      // Set/reset flop, so an off below on lands after the wrap
      always_ff @(posedge ref_clk_in) begin
         if (rst_in || full_off[c]) begin
            pwm_q[c] <= 1'b0;
         end else if (cnt_q == off_cnt[c]) begin
            pwm_q[c] <= 1'b0;
         end else if (cnt_q == on_cnt[c]) begin
            pwm_q[c] <= 1'b1;
         end
      end

      always_ff @(posedge ref_clk_in) begin
         if (rst_in) begin
            channel_output_out[c]    <= 1'b0;
            channel_output_oe_out[c] <= 1'b1;
         end else if (oe_n_q) begin
            // Override is never inverted
            channel_output_out[c]    <= outne == 2'h1 && drv;
            channel_output_oe_out[c] <= outne == 2'h0
                                        || (outne == 2'h1 && drv);
         end else if (drv) begin
            channel_output_out[c]    <= pwm_q[c] ^ inv;
            channel_output_oe_out[c] <= 1'b1;
         end else begin
            // Open drain only sinks; a high level releases the pin
            channel_output_out[c]    <= 1'b0;
            channel_output_oe_out[c] <= ~(pwm_q[c] ^ inv);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_addr_in == led_pwm_pkg::CFG_ADDR) begin
         reg_rdata_out <= {3'h0, cfg_q};
      end else if (reg_rd_addr_in >= led_pwm_pkg::CH_FIRST_ADDR
                   && reg_rd_addr_in <= led_pwm_pkg::CH_LAST_ADDR) begin
         reg_rdata_out <= stage_q[6'(reg_rd_addr_in
                                     - led_pwm_pkg::CH_FIRST_ADDR)];
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   a_invert_level: assert property (!oe_n_q && drv |=>
      channel_output_out[0] == ($past(pwm_q[0]) ^ $past(inv)))
      else $error("inverted level wrong");
   a_stop_update: assert property (!update_timing_select && bus_stop_in |=>
      act_q[3] == $past(nxt[3]) && act_q[NB-1] == $past(nxt[NB-1]))
      else $error("stop update missed");
   a_hold_until_stop: assert property (!update_timing_select && !bus_stop_in |=>
      $stable(act_q[0]) && $stable(act_q[NB-1]))
      else $error("early update");
   a_ack_update: assert property (ch_upd[0] |=>
      loaded_q[0] == 4'h0 && act_q[0] == $past(nxt[0]))
      else $error("ack update wrong");
   a_open_drain: assert property (!oe_n_q && !drv |=>
      channel_output_out == '0)
      else $error("open drain drove high");
   a_disabled_low: assert property (oe_n_q && outne == 2'h0 |=>
      channel_output_out == '0 && channel_output_oe_out == '1)
      else $error("disabled low wrong");
   a_disabled_high: assert property (oe_n_q && outne == 2'h1 && drv |=>
      channel_output_out == '1 && channel_output_oe_out == '1)
      else $error("disabled high wrong");
   a_counter_step: assert property (pwm_tick_in |=>
      cnt_q == $past(cnt_q) + led_pwm_pkg::CNT_STEP)
      else $error("counter step wrong");
   a_turn_on: assert property (cnt_q == on_cnt[0]
      && cnt_q != off_cnt[0] && !full_off[0] |=> pwm_q[0])
      else $error("channel did not turn on");
   a_turn_off: assert property (cnt_q == off_cnt[0] |=> !pwm_q[0])
      else $error("channel did not turn off");
   a_full_off: assert property (full_off[0] |=> !pwm_q[0])
      else $error("full off ignored");

   c_stop_publish: cover property (!update_timing_select && ch_wr ##[1:20] bus_stop_in);
   c_ack_publish: cover property (ch_upd[0]);
   c_wrap_pulse: cover property (off_cnt[0] < on_cnt[0] && pwm_q[0]
      && cnt_q == 12'h000);
endmodule : led_pwm_channel_output_control
`default_nettype wire

// ### led_pwm_pkg.sv
// Constants for the LED PWM channel and output configuration block
package led_pwm_pkg;
   localparam logic [7:0] CFG_ADDR      = 8'h01;
   localparam logic [7:0] CH_FIRST_ADDR = 8'h06;
   localparam logic [7:0] CH_LAST_ADDR  = 8'h45;
   localparam int         OUTNE_LSB     = 0;
   localparam int         DRV_BIT       = 2;
   localparam int         OCH_BIT       = 3;
   localparam int         INV_BIT       = 4;
   localparam logic [4:0] CFG_RESET     = 5'h04;
   localparam logic [7:0] ON_RESET      = 8'h00;
   localparam logic [7:0] OFF_H_RESET   = 8'h10;
   localparam int         FULL_OFF_BIT  = 4;
   localparam int         BYTES_PER_CH  = 4;
   localparam logic [11:0] CNT_STEP     = 12'h001;
endpackage : led_pwm_pkg

// ### i2c_ctrl_model.sv
// Register writer standing in for the bus controller
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   input  wire logic clk_in,
   output logic      wr_out,
   output logic [7:0] addr_out,
   output logic [7:0] data_out,
   output logic      stop_out
);
   initial begin
      wr_out = 1'b0;
      stop_out = 1'b0;
      addr_out = 8'h00;
      data_out = 8'h00;
   end
   // Idle lines show inverted values, never a stale byte
   task put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      wr_out = 1'b1;
      addr_out = a;
      data_out = d;
      @(posedge clk_in);
      #1;
      wr_out = 1'b0;
      addr_out = ~a;
      data_out = ~d;
   endtask : put
   // All four bytes of one channel, lowest address first
   task wr_channel(input int c, input int on, input int off);
      put(8'h06 + 8'(4 * c), 8'(on));
      put(8'h07 + 8'(4 * c), 8'(on >> 8));
      put(8'h08 + 8'(4 * c), 8'(off));
      put(8'h09 + 8'(4 * c), 8'(off >> 8));
   endtask : wr_channel
   task send_stop();
      @(posedge clk_in);
      #1;
      stop_out = 1'b1;
      @(posedge clk_in);
      #1;
      stop_out = 1'b0;
   endtask : send_stop
endmodule : i2c_ctrl_model
`default_nettype wire

// ### led_pwm_channel_output_control_test.sv
// Self-checking bench for the LED PWM channel block
`timescale 1ns/1ps
`default_nettype none
module led_pwm_channel_output_control_test;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic oe_n = 1'b0;
   logic tick = 1'b1;
   logic wr, stp;
   logic [7:0] ad, wd, rdata;
   logic [7:0] rd_addr = 8'h00;
   logic [15:0] q, oe;
   int n_errors = 0;
   int check_count = 0;
   int seed = 68;
   int act_on[16], act_off[16], hi[16];
   always #5 ref_clk_in = ~ref_clk_in;
   i2c_ctrl_model i2c_ctrl_model_i (.clk_in(ref_clk_in), .wr_out(wr),
      .addr_out(ad), .data_out(wd), .stop_out(stp));
   led_pwm_channel_output_control led_pwm_channel_output_control_i (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_wr_in(wr),
      .reg_addr_in(ad), .reg_wdata_in(wd), .bus_stop_in(stp),
      .reg_rd_addr_in(rd_addr), .reg_rdata_out(rdata), .pwm_tick_in(tick),
      .output_enable_n_in(oe_n), .channel_output_out(q),
      .channel_output_oe_out(oe));
   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task summarize();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   // Off at or above 4096 carries the full-off bit
   function int duty(int c);
      if (act_off[c] >= 4096) return 0;
      return (act_off[c] - act_on[c] + 4096) % 4096;
   endfunction : duty
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      #1 rd_addr = a;
      repeat (2) @(posedge ref_clk_in);
      #1 check(16'(rdata), 16'(e));
   endtask : rd
   // Whole period of high cycles, so output latency cannot bias it.
   // One period of settling first: a pulse that spans the update
   // point only appears once the counter has passed its on count.
   // Open drain counts a released pin as high (pull-up).
   task measure(input int inv, input int od);
      logic [15:0] seen_hi;
      seen_hi = 16'h0000;
      for (int c = 0; c < 16; c++) hi[c] = 0;
      repeat (4100) @(posedge ref_clk_in);
      repeat (4096) begin
         @(posedge ref_clk_in);
         #2;
         for (int c = 0; c < 16; c++)
            hi[c] += od ? (oe[c] === 1'b0) : (q[c] === 1'b1);
         seen_hi = seen_hi | q;
      end
      for (int c = 0; c < 16; c++)
         check(16'(hi[c]), 16'(inv ? 4096 - duty(c) : duty(c)));
      if (od) check(seen_hi, 16'h0000);
      else check(oe, 16'hFFFF);
   endtask : measure
   initial begin
      int on[16], off[16];
      logic pin_driven;
      for (int c = 0; c < 16; c++) act_off[c] = 4096;
      for (int c = 0; c < 16; c++) act_on[c] = 0;
      repeat (3) @(posedge ref_clk_in);
      #1 rst_in = 1'b0;
      rd(8'h01, 8'h04);
      rd(8'h09, 8'h10);
      rd(8'h02, 8'h00);
      $display("reset test done");
      on[0] = 12'h199; off[0] = 12'h4CC; on[4] = 12'hE65; off[4] = 12'h4CB;
      for (int c = 8; c < 12; c++) on[c] = $random(seed) & 4095;
      for (int c = 8; c < 12; c++) off[c] = $random(seed) & 4095;
      foreach (on[c]) if (c == 0 || c == 4 || c >= 8 && c < 12)
         i2c_ctrl_model_i.wr_channel(c, on[c], off[c]);
      measure(0, 0);
      i2c_ctrl_model_i.send_stop();
      foreach (on[c]) if (c == 0 || c == 4 || c >= 8 && c < 12) begin
         act_on[c] = on[c];
         act_off[c] = off[c];
      end
      measure(0, 0);
      $display("stop update test done");
      @(posedge ref_clk_in);
      #1 tick = 1'b0;
      for (int c = 0; c < 16; c++) hi[c] = 0;
      repeat (4) @(posedge ref_clk_in);
      repeat (4096) begin
         @(posedge ref_clk_in);
         #2;
         for (int c = 0; c < 16; c++) hi[c] += (q[c] === 1'b1);
      end
      // Frozen counter must leave every pin at one level
      for (int c = 0; c < 16; c++)
         check(16'(hi[c] % 4096), 16'h0000);
      @(posedge ref_clk_in);
      #1 tick = 1'b1;
      $display("tick hold test done");
      i2c_ctrl_model_i.put(8'h01, 8'h1C);
      i2c_ctrl_model_i.put(8'h0A, 8'h10);
      i2c_ctrl_model_i.put(8'h0B, 8'h00);
      i2c_ctrl_model_i.put(8'h0C, 8'h20);
      measure(1, 0);
      i2c_ctrl_model_i.put(8'h0D, 8'h03);
      act_on[1] = 12'h010;
      act_off[1] = 12'h320;
      i2c_ctrl_model_i.wr_channel(4, 0, 4096 + 100);
      act_on[4] = 0;
      act_off[4] = 4196;
      // Wrapping pulse on channel 0, published on the fourth ack
      i2c_ctrl_model_i.wr_channel(0, 12'h800, 12'h100);
      act_on[0] = 12'h800;
      act_off[0] = 12'h100;
      measure(1, 0);
      $display("ack update test done");
      @(posedge ref_clk_in);
      #1 oe_n = 1'b1;
      for (int m = 0; m < 16; m++) begin
         // Invert bit toggles too; the forced level must ignore it
         i2c_ctrl_model_i.put(8'h01, 8'({m[3], 1'b0, m[2:0]}));
         repeat (5) @(posedge ref_clk_in);
         pin_driven = !m[1] && (!m[0] || m[2]);
         #1 check(oe, pin_driven ? 16'hFFFF : 16'h0000);
         if (pin_driven)
            check(q, m[0] ? 16'hFFFF : 16'h0000);
      end
      $display("disabled state test done");
      @(posedge ref_clk_in);
      #1 oe_n = 1'b0;
      i2c_ctrl_model_i.put(8'h01, 8'h00);
      measure(0, 1);
      $display("open drain test done");
      summarize();
   end
endmodule : led_pwm_channel_output_control_test
`default_nettype wire
